// *** smbus_config_slave.sv ***
// Purpose: Select-gated serial management slave holding equalizer settings
// Assumes: 40 MHz core_clk, host drives the serial clock, open-drain data
// Notes:   Single register per write; no address auto-increment
`timescale 1ns/10ps
`include "smbus_config_defines.svh"

// Overview of operation
// - With bus-select high the port answers and registers are reachable.
// - With bus-select low all traffic is ignored and data never driven.
// - Serial port keeps working while the device sits in standby.
// - Only slave address 1010110 is answered; write byte is ac hex.
// - Data line only changes while the serial clock is low.
// - Data falling with clock high is START; restarts the bit counter.
// - Data rising with clock high is STOP; ends the message.
// - Bus goes idle after bus-free time past STOP or max clock-high.
// - Bus-free time is 4.7 us, maximum clock-high time is 50 us.
// - Write: START, address, register byte, one data byte; stored as that byte completes.
// - Acknowledge matching address, register byte and written data byte.
// - After read address ack, send selected register MSB first.
// - Both reads and writes supported; each register bit RO or RW.
// - Register 07 bit 0 picks enable pin or internal bit for standby.
// - Per-channel 3-bit boost code picks one of eight levels.
// - Two-bit swing code selects output level; resets to 1000 mV code.
module smbus_config_slave
   import smbus_config_pkg::*;
#(
   parameter logic [3:0] REV_ID = 4'h1  // Revision code, arbitrary value
) (
   input  wire logic       core_clk,        // System clock, 40 MHz
   input  wire logic       rstn,            // Async reset, active low
   input  wire logic       serialClockPin,  // Host serial clock
   input  wire logic       serialDataIn,    // Data line level
   output logic            serialDataOut,   // Data drive value, always low
   output logic            serialDataOe,    // High while pulling data low
   input  wire logic       busSelectPin,    // Port select from host
   input  wire logic       enablePin,       // External enable, high = active
   output logic [2:0]      boostLaneZero,   // Boost code, data lane 0
   output logic [2:0]      boostLaneOne,    // Boost code, data lane 1
   output logic [2:0]      boostLaneTwo,    // Boost code, data lane 2
   output logic [3:0]      laneDisable,     // {lane2, lane1, lane0, clock}
   output logic [1:0]      sigOnThresh,     // Signal-on threshold code
   output logic [1:0]      sigOffThresh,    // Signal-off threshold code
   output logic [1:0]      swingCode,       // Output swing code
   output logic            standby          // Device in standby
);
   localparam logic [11:0] BUF_CYC   = 12'(`SMB_TBUF_CYC);
   localparam logic [11:0] HIGH_CYC  = 12'(`SMB_THIGH_MAX_CYC);

   // Merge written bits with the fixed reset value of protected bits
   function automatic logic [7:0] wmerge(input logic [7:0] d, input logic [7:0] m,
                                         input logic [7:0] r);
      wmerge = (d & m) | (r & ~m);
   endfunction : wmerge

   function automatic logic regHit(input logic [7:0] a, input logic [7:0] off);
      regHit = (a == off);
   endfunction : regHit

   logic [3:0] lvl;
   logic [3:0] prv;
   smb_state_t state_q, state_d;
   logic [3:0]  bitCnt_q, bitCnt_d;
   logic [7:0]  shift_q, shift_d;
   logic [7:0]  regAddr_q, regAddr_d;
   logic        rw_q, rw_d;
   logic        mAck_q, mAck_d;
   logic        oe_q, oe_d;
   logic        wrEn;
   logic [11:0] highCnt_q;
   logic        stopSeen_q;
   logic        sdaOut_q;
   logic        standby_q;
   logic [7:0]  ctrlCh0_q, ctrlCh12_q, onThr_q, offThr_q, srcSel_q, swing_q;

   // Pins cross into core_clk through two flops
   smbus_pin_sync #(.W(4)) u_sync (
      .core_clk  (core_clk),
      .rstn      (rstn),
      .pinIn     ({enablePin, busSelectPin, serialDataIn, serialClockPin}),
      .level     (lvl),
      .prevLevel (prv)
   );

   // Bus condition decode; select low masks edges, START and STOP, not the idle timer
   wire sclS     = lvl[0];
   wire sdaS     = lvl[1];
   wire selS     = lvl[2];
   wire enS      = lvl[3];
   wire sclRise  = selS & sclS & ~prv[0];
   wire sclFall  = selS & ~sclS & prv[0];
   wire startDet = selS & sclS & prv[0] & prv[1] & ~sdaS;
   wire stopDet  = selS & sclS & prv[0] & ~prv[1] & sdaS;
   wire busHigh  = sclS & sdaS;
   wire idleHit  = (stopSeen_q && highCnt_q >= BUF_CYC) || (highCnt_q >= HIGH_CYC);
   wire addrOk   = (shift_q[7:1] == `SMB_SLAVE_ADDR);
   wire byteDone = sclFall && (bitCnt_q == 4'd8);

   // Read-back mux; unmapped offsets read zero
   wire [7:0] revByte  = {REV_ID, 4'h0};
   wire [7:0] enByte   = 8'({~standby_q, 3'b000});
   wire [7:0] readData =
      regHit(regAddr_q, `REG_REVISION)     ? revByte    :
      regHit(regAddr_q, `REG_ENABLE_STATE) ? enByte     :
      regHit(regAddr_q, `REG_CTRL_CH0)     ? ctrlCh0_q  :
      regHit(regAddr_q, `REG_CTRL_CH12)    ? ctrlCh12_q :
      regHit(regAddr_q, `REG_ON_THRESH)    ? onThr_q    :
      regHit(regAddr_q, `REG_OFF_THRESH)   ? offThr_q   :
      regHit(regAddr_q, `REG_SRC_SELECT)   ? srcSel_q   :
      regHit(regAddr_q, `REG_SWING)        ? swing_q    : 8'h00;

   // Protocol sequencer; ack and data driven only after a clock fall
   always_comb begin
      state_d   = state_q;
      bitCnt_d  = bitCnt_q;
      shift_d   = shift_q;
      regAddr_d = regAddr_q;
      rw_d      = rw_q;
      mAck_d    = mAck_q;
      oe_d      = oe_q;
      wrEn      = 1'b0;
      if (!selS) begin
         state_d = ST_IDLE;
         oe_d    = 1'b0;
      end else if (startDet) begin
         state_d  = ST_ADDR;
         bitCnt_d = 4'd0;
         oe_d     = 1'b0;
      end else if (stopDet || (idleHit && state_q != ST_IDLE)) begin
         state_d = ST_IDLE;
         oe_d    = 1'b0;
      end else begin
         case (state_q)
            ST_ADDR, ST_REG, ST_WDATA: begin
               if (sclRise && bitCnt_q < 4'd8) begin
                  shift_d  = {shift_q[6:0], sdaS};
                  bitCnt_d = bitCnt_q + 4'd1;
               end else if (byteDone) begin
                  bitCnt_d = 4'd0;
                  oe_d     = 1'b1;
                  if (state_q == ST_ADDR) begin
                     rw_d    = shift_q[0];
                     state_d = addrOk ? ST_ADDR_ACK : ST_IGNORE;
                     oe_d    = addrOk;
                  end else if (state_q == ST_REG) begin
                     regAddr_d = shift_q;
                     state_d   = ST_REG_ACK;
                  end else begin
                     wrEn    = 1'b1;
                     state_d = ST_WDATA_ACK;
                  end
               end
            end
            ST_ADDR_ACK: begin
               if (sclFall) begin
                  if (rw_q) begin
                     state_d  = ST_RDATA;
                     shift_d  = readData;
                     oe_d     = ~readData[7];
                     bitCnt_d = 4'd0;
                  end else begin
                     state_d = ST_REG;
                     oe_d    = 1'b0;
                  end
               end
            end
            ST_REG_ACK: begin
               if (sclFall) begin
                  state_d = ST_WDATA;
                  oe_d    = 1'b0;
               end
            end
            ST_WDATA_ACK: begin
               if (sclFall) begin
                  state_d = ST_IGNORE;   // Extra bytes are not acked
                  oe_d    = 1'b0;
               end
            end
            ST_RDATA: begin
               if (sclFall) begin
                  if (bitCnt_q == 4'd7) begin
                     state_d = ST_RDATA_ACK;
                     oe_d    = 1'b0;
                  end else begin
                     bitCnt_d = bitCnt_q + 4'd1;
                     shift_d  = {shift_q[6:0], 1'b0};
                     oe_d     = ~shift_q[6];
                  end
               end
            end
            ST_RDATA_ACK: begin
               if (sclRise) begin
                  mAck_d = ~sdaS;
               end else if (sclFall) begin
                  if (mAck_q) begin
                     state_d  = ST_RDATA;
                     shift_d  = readData;
                     oe_d     = ~readData[7];
                     bitCnt_d = 4'd0;
                  end else begin
                     state_d = ST_IGNORE;
                  end
               end
            end
            ST_IDLE, ST_IGNORE: begin
               oe_d = 1'b0;
            end
            default: begin
               state_d = ST_IDLE;
               oe_d    = 1'b0;
            end
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         state_q   <= ST_IDLE;
         bitCnt_q  <= 4'd0;
         shift_q   <= 8'h00;
         regAddr_q <= 8'h00;
         rw_q      <= 1'b0;
         mAck_q    <= 1'b0;
         oe_q      <= 1'b0;
      end else begin
         state_q   <= state_d;
         bitCnt_q  <= bitCnt_d;
         shift_q   <= shift_d;
         regAddr_q <= regAddr_d;
         rw_q      <= rw_d;
         mAck_q    <= mAck_d;
         oe_q      <= oe_d;
      end
   end

   // Idle timer: saturates so a parked bus never wraps back to busy
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         highCnt_q  <= 12'h000;
         stopSeen_q <= 1'b0;
      end else begin
         highCnt_q  <= !busHigh ? 12'h000 : (highCnt_q == HIGH_CYC) ? highCnt_q
                       : highCnt_q + 12'h001;
         stopSeen_q <= stopDet | (stopSeen_q & ~startDet);
      end
   end

   // Configuration storage; read-only offsets and reserved bits unaffected
   wire wCh0  = wrEn && regHit(regAddr_q, `REG_CTRL_CH0);
   wire wCh12 = wrEn && regHit(regAddr_q, `REG_CTRL_CH12);
   wire wOn   = wrEn && regHit(regAddr_q, `REG_ON_THRESH);
   wire wOff  = wrEn && regHit(regAddr_q, `REG_OFF_THRESH);
   wire wSrc  = wrEn && regHit(regAddr_q, `REG_SRC_SELECT);
   wire wSwg  = wrEn && regHit(regAddr_q, `REG_SWING);

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         ctrlCh0_q  <= `RST_CTRL_CH0;
         ctrlCh12_q <= `RST_CTRL_CH12;
         onThr_q    <= `RST_ON_THRESH;
         offThr_q   <= `RST_OFF_THRESH;
         srcSel_q   <= `RST_SRC_SELECT;
         swing_q    <= `RST_SWING;
      end else begin
         if (wCh0)  ctrlCh0_q  <= wmerge(shift_q, `WMASK_CTRL_CH0, `RST_CTRL_CH0);
         if (wCh12) ctrlCh12_q <= wmerge(shift_q, `WMASK_CTRL_CH12, `RST_CTRL_CH12);
         if (wOn)   onThr_q    <= wmerge(shift_q, `WMASK_THRESH, `RST_ON_THRESH);
         if (wOff)  offThr_q   <= wmerge(shift_q, `WMASK_THRESH, `RST_OFF_THRESH);
         if (wSrc)  srcSel_q   <= wmerge(shift_q, `WMASK_SRC_SELECT, `RST_SRC_SELECT);
         if (wSwg)  swing_q    <= wmerge(shift_q, `WMASK_SWING, `RST_SWING);
      end
   end

   // Standby from internal bit or enable pin, lane outputs not gated by it; the serial port keeps running
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         standby_q <= 1'b0;
         sdaOut_q  <= 1'b0;
      end else begin
         standby_q <= srcSel_q[0] ? ctrlCh0_q[`FLD_EN_LO] : ~enS;
         sdaOut_q  <= 1'b0;
      end
   end

   // Outputs straight from registers
   assign serialDataOut = sdaOut_q;
   assign serialDataOe  = oe_q;
   assign boostLaneZero = ctrlCh0_q[`FLD_BOOST_HI +: 3];
   assign boostLaneOne  = ctrlCh12_q[`FLD_BOOST_LO +: 3];
   assign boostLaneTwo  = ctrlCh12_q[`FLD_BOOST_HI +: 3];
   assign laneDisable   = {ctrlCh12_q[`FLD_EN_HI], ctrlCh12_q[`FLD_EN_LO],
                           ctrlCh0_q[`FLD_EN_HI], ctrlCh0_q[`FLD_EN_LO]};
   assign sigOnThresh   = onThr_q[1:0];
   assign sigOffThresh  = offThr_q[1:0];
   assign swingCode     = swing_q[`FLD_SWING +: 2];
   assign standby       = standby_q;

   // Checks on the port behaviour
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);

   property p_sel_low_quiet;
      !selS |=> !oe_q && state_q == ST_IDLE;
   endproperty
   a_sel_low_quiet: assert property (p_sel_low_quiet) else $error("driven while deselected");

   property p_start_restart;
      startDet |=> state_q == ST_ADDR && bitCnt_q == 4'd0;
   endproperty
   a_start_restart: assert property (p_start_restart) else $error("start not taken");

   property p_stop_ends;
      stopDet |=> state_q == ST_IDLE && !oe_q;
   endproperty
   a_stop_ends: assert property (p_stop_ends) else $error("stop not taken");

   property p_high_timeout;
      selS && !startDet && highCnt_q == HIGH_CYC |=> state_q == ST_IDLE;
   endproperty
   a_high_timeout: assert property (p_high_timeout) else $error("idle not reached");

   property p_addr_ack;
      state_q == ST_ADDR && byteDone && selS && addrOk |=> oe_q ##1 oe_q;
   endproperty
   a_addr_ack: assert property (p_addr_ack) else $error("address not acked");

   property p_addr_nack;
      state_q == ST_ADDR && byteDone && selS && !addrOk |=> state_q == ST_IGNORE && !oe_q;
   endproperty
   a_addr_nack: assert property (p_addr_nack) else $error("bad address acked");

   property p_read_msb;
      state_q == ST_ADDR_ACK && rw_q && sclFall && !startDet && !stopDet
         |=> oe_q == ~$past(readData[7]) && state_q == ST_RDATA;
   endproperty
   a_read_msb: assert property (p_read_msb) else $error("msb not presented");

   property p_oe_rise_clock_low;
      $rose(oe_q) |-> !sclS;
   endproperty
   a_oe_rise_clock_low: assert property (p_oe_rise_clock_low) else $error("drive with clock high");

   property p_ro_write_still;
      wrEn && (regAddr_q == `REG_REVISION || regAddr_q == `REG_ENABLE_STATE)
         |=> $stable(ctrlCh0_q) && $stable(ctrlCh12_q) && $stable(onThr_q)
             && $stable(offThr_q) && $stable(srcSel_q) && $stable(swing_q);
   endproperty
   a_ro_write_still: assert property (p_ro_write_still) else $error("read-only write leaked");

   property p_swing_write;
      wSwg |=> swingCode == $past(shift_q[3:2]) && swing_q[7:4] == 4'h7;
   endproperty
   a_swing_write: assert property (p_swing_write) else $error("swing write wrong");

   property p_standby_src;
      ##1 standby_q == ($past(srcSel_q[0]) ? $past(ctrlCh0_q[3]) : ~$past(enS));
   endproperty
   a_standby_src: assert property (p_standby_src) else $error("standby source wrong");

   c_write_done: cover property (state_q == ST_WDATA_ACK ##[1:400] state_q == ST_IGNORE);
   c_read_nack: cover property (state_q == ST_RDATA_ACK ##[1:400] state_q == ST_IGNORE);
   c_addr_miss: cover property (state_q == ST_ADDR ##1 state_q == ST_IGNORE);
   c_parked: cover property (state_q != ST_IDLE && highCnt_q == HIGH_CYC);
endmodule : smbus_config_slave

// *** smbus_config_defines.svh ***
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 40 MHz core clock, register port on the serial management pins
// Notes:   Definitions only; included by bare name
`ifndef SMBUS_CONFIG_DEFINES_SVH
`define SMBUS_CONFIG_DEFINES_SVH

// Fixed 7-bit slave address (write byte 8'hac)
`define SMB_SLAVE_ADDR     7'h56

// Register offsets
`define REG_REVISION       8'h00
`define REG_ENABLE_STATE   8'h01
`define REG_CTRL_CH0       8'h02
`define REG_CTRL_CH12      8'h04
`define REG_ON_THRESH      8'h05
`define REG_OFF_THRESH     8'h06
`define REG_SRC_SELECT     8'h07
`define REG_SWING          8'h08

// Reset values
`define RST_CTRL_CH0       8'h77
`define RST_CTRL_CH12      8'h77
`define RST_ON_THRESH      8'h00
`define RST_OFF_THRESH     8'h00
`define RST_SRC_SELECT     8'h00
`define RST_SWING          8'h78

// Writable bit masks; other bits keep their reset value
`define WMASK_CTRL_CH0     8'hf8
`define WMASK_CTRL_CH12    8'hff
`define WMASK_THRESH       8'h03
`define WMASK_SRC_SELECT   8'h01
`define WMASK_SWING        8'h0c

// Field positions
`define FLD_EN_HI          7
`define FLD_BOOST_HI       4
`define FLD_EN_LO          3
`define FLD_BOOST_LO       0
`define FLD_SWING          2
`define FLD_STAT_EN        3
`define FLD_REV            4

// Timing: figures in ns, counts derived from the clock period
`define SMB_CLK_NS         25
`define SMB_TBUF_NS        4700
`define SMB_THIGH_MAX_NS   50000
`define SMB_TBUF_CYC       ((`SMB_TBUF_NS + `SMB_CLK_NS - 1) / `SMB_CLK_NS)
`define SMB_THIGH_MAX_CYC  (`SMB_THIGH_MAX_NS / `SMB_CLK_NS)

`endif

// *** smbus_config_pkg.sv ***
// Purpose: Types shared by the configuration port
// Assumes: Constants live in smbus_config_defines.svh
// Notes:   One-hot protocol states
package smbus_config_pkg;

   typedef enum logic [9:0] {
      ST_IDLE      = 10'b00_0000_0001,
      ST_ADDR      = 10'b00_0000_0010,
      ST_ADDR_ACK  = 10'b00_0000_0100,
      ST_REG       = 10'b00_0000_1000,
      ST_REG_ACK   = 10'b00_0001_0000,
      ST_WDATA     = 10'b00_0010_0000,
      ST_WDATA_ACK = 10'b00_0100_0000,
      ST_RDATA     = 10'b00_1000_0000,
      ST_RDATA_ACK = 10'b01_0000_0000,
      ST_IGNORE    = 10'b10_0000_0000
   } smb_state_t;

endpackage : smbus_config_pkg

// *** smbus_pin_sync.sv ***
// Purpose: Two-stage synchroniser for pin inputs, plus one delayed copy
// Assumes: Inputs are asynchronous to core_clk
// Notes:   Only the second stage and its delayed copy leave this module
`timescale 1ns/10ps
module smbus_pin_sync #(
   parameter int W = 4
) (
   input  wire logic         core_clk,  // System clock
   input  wire logic         rstn,      // Async reset, active low
   input  wire logic [W-1:0] pinIn,     // Raw pin levels
   output logic      [W-1:0] level,     // Synchronised level
   output logic      [W-1:0] prevLevel  // Level one cycle earlier
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;
   logic [W-1:0] dly_q;

   // Pins idle high on this bus, so reset to all ones avoids false edges
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '1;
         sync_q <= '1;
         dly_q  <= '1;
      end else begin
         meta_q <= pinIn;
         sync_q <= meta_q;
         dly_q  <= sync_q;
      end
   end

   assign level     = sync_q;
   assign prevLevel = dly_q;
endmodule : smbus_pin_sync

// *** smbus_host_model.sv ***
// Purpose: Behavioural host master for the select-gated serial port
// Assumes: Open-drain data with pull-up, bit time of four Q core cycles
// Notes:   Tasks are called by the testbench through the instance
`timescale 1ns/10ps
module smbus_host_model #(
   parameter int Q = 100  // Core cycles per quarter bit, 10 us bit time
) (
   input  wire logic core_clk,        // System clock
   input  wire logic serialDataOe,    // Device pulling data low
   output logic      serialClockPin,  // Serial clock from host
   output logic      serialDataIn,    // Resolved data wire
   output logic      busSelectPin     // Port select
);
   logic hostLow;  // Host pulling data low

   // Wire-AND with pull-up, so a released line reads high
   assign serialDataIn = ~(hostLow | serialDataOe);

   // Bus idle, device deselected
   initial begin
      serialClockPin = 1'b1;
      hostLow        = 1'b0;
      busSelectPin   = 1'b0;
   end

   // Quarter bit wait
   task automatic qw;
      repeat (Q) @(posedge core_clk);
   endtask : qw

   // One bit; data changes only in the clock-low phase
   task automatic bit_io(input logic b, output logic r);
      hostLow <= ~b;
      qw();
      serialClockPin <= 1'b1;
      qw();
      r = serialDataIn;  // Sampled mid high phase, device settled
      qw();
      serialClockPin <= 1'b0;
      qw();
   endtask : bit_io

   // Start or repeated start
   task automatic start_c;
      hostLow <= 1'b0;
      qw();
      serialClockPin <= 1'b1;
      qw();
      hostLow <= 1'b1;
      qw();
      serialClockPin <= 1'b0;
      qw();
   endtask : start_c

   // Stop, then bus-free time of two quarters
   task automatic stop_c;
      hostLow <= 1'b1;
      qw();
      serialClockPin <= 1'b1;
      qw();
      hostLow <= 1'b0;
      qw();
      qw();
   endtask : stop_c

   // Start, then park both lines high for n cycles before a clean stop
   task automatic park(input int n);
      busSelectPin <= 1'b1;
      qw();
      start_c();
      hostLow <= 1'b0;
      qw();
      serialClockPin <= 1'b1;
      repeat (n) @(posedge core_clk);
      serialClockPin <= 1'b0;  // Clock low first, no false start
      qw();
      stop_c();
      busSelectPin <= 1'b0;
      qw();
   endtask : park

   // Byte MSB first plus acknowledge slot
   task automatic byte_io(input logic [7:0] b, output logic [7:0] r, output logic acked);
      logic x;
      for (int i = 7; i >= 0; i--) begin
         bit_io(b[i], x);
         r[i] = x;
      end
      bit_io(1'b1, x);
      acked = ~x;
   endtask : byte_io

   // Whole write or read transaction
   task automatic access(input logic [7:0] dev, input logic [7:0] regA, input logic [7:0] wd,
                         input logic rd, input logic sel, output logic [7:0] rdData,
                         output logic ok);
      logic [7:0] junk;
      logic       a0;
      logic       a1;
      logic       a2;
      logic       nk;
      busSelectPin <= sel;
      qw();
      start_c();
      byte_io(dev, junk, a0);
      a1     = 1'b0;
      a2     = 1'b0;
      rdData = 8'h00;
      if (a0) begin
         byte_io(regA, junk, a1);
         if (rd) begin
            start_c();
            byte_io(dev | 8'h01, junk, a2);
            byte_io(8'hff, rdData, nk);
         end else begin
            byte_io(wd, junk, a2);
         end
      end
      stop_c();
      busSelectPin <= 1'b0;
      qw();
      ok = a0 & a1 & a2;
   endtask : access
endmodule : smbus_host_model

// *** smbus_config_slave_tb.sv ***
// Purpose: Self-checking bench for the serial configuration port
// Assumes: Host model drives the serial clock with a 200 ns period
// Notes:   Each acked transaction costs about 240 to 320 core cycles
`timescale 1ns/10ps
module smbus_config_slave_tb;
   localparam logic [3:0] REV = 4'h5;  // Revision code, arbitrary value

   logic       core_clk;
   logic       rstn;
   logic       enablePin;
   logic       serialClockPin;
   logic       serialDataIn;
   logic       serialDataOut;
   logic       serialDataOe;
   logic       busSelectPin;
   logic [2:0] boostLaneZero;
   logic [2:0] boostLaneOne;
   logic [2:0] boostLaneTwo;
   logic [3:0] laneDisable;
   logic [1:0] sigOnThresh;
   logic [1:0] sigOffThresh;
   logic [1:0] swingCode;
   logic       standby;
   logic [7:0] rdv;
   logic       ok;
   int         errorCnt  = 0;
   int         nCompared = 0;
   int         cycles    = 0;

   smbus_config_slave #(.REV_ID(REV)) DUT (
      .core_clk(core_clk), .rstn(rstn), .serialClockPin(serialClockPin),
      .serialDataIn(serialDataIn), .serialDataOut(serialDataOut),
      .serialDataOe(serialDataOe), .busSelectPin(busSelectPin), .enablePin(enablePin),
      .boostLaneZero(boostLaneZero), .boostLaneOne(boostLaneOne),
      .boostLaneTwo(boostLaneTwo), .laneDisable(laneDisable), .sigOnThresh(sigOnThresh),
      .sigOffThresh(sigOffThresh), .swingCode(swingCode), .standby(standby));

   smbus_host_model #(.Q(2)) host (
      .core_clk(core_clk), .serialDataOe(serialDataOe), .serialClockPin(serialClockPin),
      .serialDataIn(serialDataIn), .busSelectPin(busSelectPin));

   // Clock, 25 ns period
   initial core_clk = 1'b0;
   always #12.5 core_clk = ~core_clk;

   task automatic give_verdict;
      $display("compared %0d mismatches %0d", nCompared, errorCnt);
      if (errorCnt == 0 && nCompared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : give_verdict

   task automatic check8(input string what, input logic [7:0] exp, input logic [7:0] got);
      nCompared++;
      if (got !== exp) begin
         errorCnt++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask : check8

   // Write with expected acknowledge outcome
   task automatic wr(input logic [7:0] dev, input logic [7:0] a, input logic [7:0] d,
                     input logic sel, input logic expOk);
      host.access(dev, a, d, 1'b0, sel, rdv, ok);
      check8("write ack", {7'h00, expOk}, {7'h00, ok});
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      host.access(8'hac, a, 8'h00, 1'b1, 1'b1, rdv, ok);
      check8("read ack", 8'h01, {7'h00, ok});
      check8("read data", exp, rdv);
   endtask : rd

   // Hang guard, run needs about 5k cycles
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         errorCnt++;
         give_verdict();
      end
   end

   initial begin
      rstn      = 1'b0;
      enablePin = 1'b1;
      repeat (2) @(posedge core_clk);
      rstn <= 1'b1;
      repeat (4) @(posedge core_clk);
      check8("swing reset", 8'h02, {6'h00, swingCode});
      check8("boost reset", 8'h07, {5'h00, boostLaneZero});
      check8("data drive", 8'h00, {7'h00, serialDataOut});
      wr(8'hac, 8'h08, 8'hff, 1'b1, 1'b1);
      check8("swing code", 8'h03, {6'h00, swingCode});
      rd(8'h08, 8'h7c);
      wr(8'hac, 8'h04, 8'h5a, 1'b1, 1'b1);
      check8("lane1 boost", 8'h02, {5'h00, boostLaneOne});
      check8("lane2 boost", 8'h05, {5'h00, boostLaneTwo});
      check8("lane disable", 8'h04, {4'h0, laneDisable});
      wr(8'hac, 8'h06, 8'hfe, 1'b1, 1'b1);
      check8("off threshold", 8'h02, {6'h00, sigOffThresh});
      // Pin source: low enable pin means standby
      enablePin <= 1'b0;
      repeat (8) @(posedge core_clk);
      check8("pin standby", 8'h01, {7'h00, standby});
      enablePin <= 1'b1;
      repeat (8) @(posedge core_clk);
      wr(8'hac, 8'h07, 8'h01, 1'b1, 1'b1);
      check8("internal active", 8'h00, {7'h00, standby});
      wr(8'hac, 8'h02, 8'h08, 1'b1, 1'b1);
      check8("internal standby", 8'h01, {7'h00, standby});
      check8("lane0 boost", 8'h00, {5'h00, boostLaneZero});
      // Port keeps working in standby; read-only write ignored
      wr(8'hac, 8'h01, 8'hff, 1'b1, 1'b1);
      rd(8'h01, 8'h00);
      rd(8'h00, {REV, 4'h0});
      wr(8'hae, 8'h05, 8'h03, 1'b1, 1'b0);
      wr(8'hac, 8'h05, 8'h03, 1'b0, 1'b0);
      check8("threshold kept", 8'h00, {6'h00, sigOnThresh});
      host.park(2100);
      wr(8'hac, 8'h05, 8'h03, 1'b1, 1'b1);
      check8("threshold set", 8'h03, {6'h00, sigOnThresh});
      give_verdict();
   end
endmodule : smbus_config_slave_tb
